// ### ptf_params.svh
// constants for the 10 Mbps transmit timing, heartbeat and link pulse block
// assumes a 100 MHz system clock; every cycle count derives from a time here
`ifndef PTF_PARAMS_SVH
`define PTF_PARAMS_SVH

`define PTF_CLK_NS 10
`define PTF_BT_NS 100
`define PTF_BT_CYC (`PTF_BT_NS / `PTF_CLK_NS)
`define PTF_CRS_ON_BT 2
`define PTF_CRS_OFF_BT 1
`define PTF_TX_LAT_TENTH_BT 725
`define PTF_TX_LAT_CYC \
    (`PTF_TX_LAT_TENTH_BT * `PTF_BT_NS / (10 * `PTF_CLK_NS))
`define PTF_JAB_MS 20
`define PTF_JAB_CYC (`PTF_JAB_MS * 1000000 / `PTF_CLK_NS)
`define PTF_UNJAB_MS 250
`define PTF_UNJAB_CYC (`PTF_UNJAB_MS * 1000000 / `PTF_CLK_NS)
`define PTF_SQE_DLY_NS 650
`define PTF_SQE_DLY_CYC ((`PTF_SQE_DLY_NS + `PTF_CLK_NS - 1) / `PTF_CLK_NS)
`define PTF_SQE_PW_NS 500
`define PTF_SQE_PW_CYC ((`PTF_SQE_PW_NS + `PTF_CLK_NS - 1) / `PTF_CLK_NS)
`define PTF_FLP_PW_NS 100
`define PTF_FLP_PW_CYC (`PTF_FLP_PW_NS / `PTF_CLK_NS)
`define PTF_FLP_DATA_NS 55500
`define PTF_FLP_DATA_CYC \
    ((`PTF_FLP_DATA_NS + `PTF_CLK_NS - 1) / `PTF_CLK_NS)
`define PTF_FLP_CLK_NS 123000
`define PTF_FLP_CLK_CYC ((`PTF_FLP_CLK_NS + `PTF_CLK_NS - 1) / `PTF_CLK_NS)
`define PTF_FLP_INT_MS 12
`define PTF_FLP_INT_CYC (`PTF_FLP_INT_MS * 1000000 / `PTF_CLK_NS)
`define PTF_FLP_WORD_W 16
`define PTF_RST_REC_US 300
`define PTF_RST_REC_CYC (`PTF_RST_REC_US * 1000 / `PTF_CLK_NS)
`define PTF_NIB_W 4
`define PTF_FIFO_DEPTH 16

`endif

// ### ptf_pkg.sv
// types shared by the transmit timing block and its fifo
// assumes ptf_params.svh is on the include path
`include "ptf_params.svh"
package ptf_pkg;
    typedef struct packed {
        logic [`PTF_NIB_W-1:0] data;
    } ptf_nib_t;

    typedef enum logic [1:0] {
        PTF_SER_IDLE = 2'b00,
        PTF_SER_LEAD = 2'b01,
        PTF_SER_SEND = 2'b10
    } ptf_ser_t;

    typedef enum logic {
        PTF_FLP_WAIT = 1'b0,
        PTF_FLP_BURST = 1'b1
    } ptf_flp_t;
endpackage

// ### ptf_top.sv
// 10 Mbps transmit path: carrier sense, jabber, heartbeat, link pulses
// assumes MII transmit inputs launched on i_tx_clk; control from i_clk logic
`timescale 1ns/1ps
`include "ptf_params.svh"

module ptf_async_fifo #(
    parameter int W = 4,
    parameter int DEPTH = 16
) (
    // write side
    input wire logic i_wclk,
    input wire logic i_wreset_n,
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // read side
    input wire logic i_rclk,
    input wire logic i_rreset_n,
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wbin_reg, wgray_reg, wbin_next, wgray_next;
    logic [AW:0] rbin_reg, rgray_reg, rbin_next, rgray_next;
    logic [AW:0] rq1_reg, rq2_reg, wq1_reg, wq2_reg;
    logic push, pop;

    assign push = i_wr_valid & o_wr_ready;
    assign pop = i_rd_ready & o_rd_valid;
    assign wbin_next = wbin_reg + {{AW{1'b0}}, push};
    assign wgray_next = (wbin_next >> 1) ^ wbin_next;
    assign rbin_next = rbin_reg + {{AW{1'b0}}, pop};
    assign rgray_next = (rbin_next >> 1) ^ rbin_next;
    assign o_rd_data = mem[rbin_reg[AW-1:0]];

    always_ff @(posedge i_wclk) begin
        if (push) begin
            mem[wbin_reg[AW-1:0]] <= i_wr_data;
        end
    end

    // gray pointers cross, each through two flops
    always_ff @(posedge i_wclk or negedge i_wreset_n) begin
        if (!i_wreset_n) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rq1_reg <= '0;
            rq2_reg <= '0;
            o_wr_ready <= 1'b0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= wgray_next;
            rq1_reg <= rgray_reg;
            rq2_reg <= rq1_reg;
            o_wr_ready <= wgray_next !=
                {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
        end
    end

    always_ff @(posedge i_rclk or negedge i_rreset_n) begin
        if (!i_rreset_n) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wq1_reg <= '0;
            wq2_reg <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= rgray_next;
            wq1_reg <= wgray_reg;
            wq2_reg <= wq1_reg;
            o_rd_valid <= rgray_next != wq2_reg;
        end
    end
endmodule

// Functional notes
// - carrier sense rises two bit times after transmit enable is seen high
// - carrier sense falls one bit time after transmit enable is seen low
// - first line symbol leaves 72.5 bit times after transmit enable rises
// - one bit time is 100 ns at 10 Mbps
// - overlong transmission enters jabber; leaves after the unjabber interval
// - heartbeat starts 0.65 to 1.6 us after transmit enable falls
// - heartbeat pulse lasts 0.5 to 1.5 us
// - each link pulse is about 100 ns wide
// - data pulse follows clock pulse by 55.5 to 63.8 us, present for a one
// - clock pulses in a burst are 123 to 127 us apart
// - bursts last about 2 ms and start 8 to 24 ms apart
// - a burst holds 17 to 33 pulses in all
// - internal reset ends within 300 us of power reaching threshold
// - device is operational within 300 us of hardware reset release
module ptf_top #(
    parameter int unsigned JAB_CYC = `PTF_JAB_CYC,
    parameter int unsigned UNJAB_CYC = `PTF_UNJAB_CYC,
    parameter int unsigned FLP_DATA_CYC = `PTF_FLP_DATA_CYC,
    parameter int unsigned FLP_CLK_CYC = `PTF_FLP_CLK_CYC,
    parameter int unsigned FLP_INT_CYC = `PTF_FLP_INT_CYC,
    parameter int unsigned RST_REC_CYC = `PTF_RST_REC_CYC
) (
    // system clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // controller transmit interface, link clock domain
    input wire logic i_tx_clk,
    input wire logic i_tx_en,
    input wire logic [`PTF_NIB_W-1:0] i_txd,
    output logic o_tx_ready,
    // control from system logic
    input wire logic i_mode_10m,
    input wire logic i_autoneg_en,
    input wire logic [`PTF_FLP_WORD_W-1:0] i_flp_word,
    // status and line
    output logic o_crs,
    output logic o_col,
    output logic o_jabber,
    output logic o_phy_ready,
    output logic o_twisted_pair_tx_out
);
    logic lrst1_reg, lrst2_reg;
    logic ltx_en_reg;
    ptf_pkg::ptf_nib_t ltxd_reg, rd_nib;
    logic rd_valid, rd_ready;
    logic ten1_reg, ten_reg, ten_d_reg;
    logic [31:0] rec_cnt_reg;
    logic [7:0] crs_cnt_reg;
    logic [31:0] jab_cnt_reg;
    logic sqe_wait_reg, sqe_on_reg;
    logic [7:0] sqe_cnt_reg;
    ptf_pkg::ptf_ser_t ser_reg;
    logic [9:0] lead_cnt_reg;
    logic [`PTF_NIB_W-1:0] sh_reg;
    logic [2:0] bits_reg;
    logic [3:0] bcyc_reg;
    ptf_pkg::ptf_flp_t flp_reg;
    logic [31:0] flp_int_reg, flp_t_reg;
    logic [4:0] flp_idx_reg;
    logic en10, drop, tx_busy, flp_en, flp_pulse, ser_bit, ten_rise, ten_fall;

    // link domain reset: asserts at once, releases on the link clock
    always_ff @(posedge i_tx_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lrst1_reg <= 1'b0;
            lrst2_reg <= 1'b0;
        end else begin
            lrst1_reg <= 1'b1;
            lrst2_reg <= lrst1_reg;
        end
    end

    always_ff @(posedge i_tx_clk or negedge lrst2_reg) begin
        if (!lrst2_reg) begin
            ltx_en_reg <= 1'b0;
            ltxd_reg <= '0;
        end else begin
            ltx_en_reg <= i_tx_en;
            ltxd_reg.data <= i_txd;
        end
    end

    // a full fifo drops o_tx_ready; nibbles offered meanwhile are lost
    ptf_async_fifo #(
        .W(`PTF_NIB_W),
        .DEPTH(`PTF_FIFO_DEPTH)
    ) u_fifo (
        .i_wclk(i_tx_clk),
        .i_wreset_n(lrst2_reg),
        .i_wr_valid(ltx_en_reg),
        .i_wr_data(ltxd_reg),
        .o_wr_ready(o_tx_ready),
        .i_rclk(i_clk),
        .i_rreset_n(i_reset_n),
        .o_rd_valid(rd_valid),
        .o_rd_data(rd_nib),
        .i_rd_ready(rd_ready)
    );

    // transmit enable level into the system domain
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ten1_reg <= 1'b0;
            ten_reg <= 1'b0;
            ten_d_reg <= 1'b0;
        end else begin
            ten1_reg <= ltx_en_reg;
            ten_reg <= ten1_reg;
            ten_d_reg <= ten_reg;
        end
    end

    assign ten_rise = ten_reg & ~ten_d_reg;
    assign ten_fall = ~ten_reg & ten_d_reg;
    assign en10 = i_mode_10m & o_phy_ready;
    assign drop = ~en10 | o_jabber;
    assign tx_busy = ten_reg | (ser_reg != ptf_pkg::PTF_SER_IDLE);

    // recovery after reset; the async reset itself may be very short
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rec_cnt_reg <= 32'h0000_0000;
            o_phy_ready <= 1'b0;
        end else if (!o_phy_ready) begin
            rec_cnt_reg <= rec_cnt_reg + 32'h0000_0001;
            o_phy_ready <= rec_cnt_reg >= RST_REC_CYC - 1;
        end
    end

    // carrier sense follows transmit enable after a bit-time delay
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            crs_cnt_reg <= 8'h00;
            o_crs <= 1'b0;
        end else if ((ten_reg & en10) == o_crs) begin
            crs_cnt_reg <= 8'h00;
        end else if (crs_cnt_reg == 8'(o_crs ?
                `PTF_CRS_OFF_BT * `PTF_BT_CYC - 1 :
                `PTF_CRS_ON_BT * `PTF_BT_CYC - 1)) begin
            crs_cnt_reg <= 8'h00;
            o_crs <= ~o_crs;
        end else begin
            crs_cnt_reg <= crs_cnt_reg + 8'h01;
        end
    end

    // one counter serves both the jabber limit and the unjabber wait
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            jab_cnt_reg <= 32'h0000_0000;
            o_jabber <= 1'b0;
        end else if (!o_jabber) begin
            if (!(ten_reg & en10)) begin
                jab_cnt_reg <= 32'h0000_0000;
            end else if (jab_cnt_reg >= JAB_CYC - 1) begin
                jab_cnt_reg <= 32'h0000_0000;
                o_jabber <= 1'b1;
            end else begin
                jab_cnt_reg <= jab_cnt_reg + 32'h0000_0001;
            end
        end else if (ten_reg) begin
            jab_cnt_reg <= 32'h0000_0000;
        end else if (jab_cnt_reg >= UNJAB_CYC - 1) begin
            jab_cnt_reg <= 32'h0000_0000;
            o_jabber <= 1'b0;
        end else begin
            jab_cnt_reg <= jab_cnt_reg + 32'h0000_0001;
        end
    end

    // heartbeat after each frame that ends in 10 Mbps mode outside jabber; a new frame cancels a pending one
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sqe_wait_reg <= 1'b0;
            sqe_on_reg <= 1'b0;
            sqe_cnt_reg <= 8'h00;
        end else if (ten_rise) begin
            sqe_wait_reg <= 1'b0;
            sqe_on_reg <= 1'b0;
            sqe_cnt_reg <= 8'h00;
        end else if (ten_fall & ~drop) begin
            sqe_wait_reg <= 1'b1;
            sqe_cnt_reg <= 8'h00;
        end else if (sqe_wait_reg) begin
            sqe_cnt_reg <= sqe_cnt_reg + 8'h01;
            if (sqe_cnt_reg == 8'(`PTF_SQE_DLY_CYC - 1)) begin
                sqe_wait_reg <= 1'b0;
                sqe_on_reg <= 1'b1;
                sqe_cnt_reg <= 8'h00;
            end
        end else if (sqe_on_reg) begin
            sqe_cnt_reg <= sqe_cnt_reg + 8'h01;
            if (sqe_cnt_reg == 8'(`PTF_SQE_PW_CYC - 1)) begin
                sqe_on_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_col <= 1'b0;
        end else begin
            o_col <= sqe_on_reg | o_jabber;
        end
    end

    // serializer: lead-in delay, then nibbles lsb first, Manchester coded
    // next nibble taken in the last bit cycle, so bits stay back to back
    assign rd_ready = drop | ((ser_reg == ptf_pkg::PTF_SER_SEND) &
        ((bits_reg == 3'd0) | ((bits_reg == 3'd1) &
        (bcyc_reg == 4'(`PTF_BT_CYC - 1)))));

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ser_reg <= ptf_pkg::PTF_SER_IDLE;
            lead_cnt_reg <= 10'h000;
            sh_reg <= '0;
            bits_reg <= 3'd0;
            bcyc_reg <= 4'h0;
        end else if (drop) begin
            ser_reg <= ptf_pkg::PTF_SER_IDLE;
            bits_reg <= 3'd0;
        end else begin
            unique case (ser_reg)
                ptf_pkg::PTF_SER_IDLE: begin
                    lead_cnt_reg <= 10'h000;
                    if (ten_rise) begin
                        ser_reg <= ptf_pkg::PTF_SER_LEAD;
                    end
                end
                ptf_pkg::PTF_SER_LEAD: begin
                    lead_cnt_reg <= lead_cnt_reg + 10'h001;
                    if (lead_cnt_reg == 10'(`PTF_TX_LAT_CYC - 1)) begin
                        ser_reg <= ptf_pkg::PTF_SER_SEND;
                    end
                end
                ptf_pkg::PTF_SER_SEND: begin
                    if (bits_reg == 3'd0) begin
                        bcyc_reg <= 4'h0;
                        if (rd_valid) begin
                            sh_reg <= rd_nib.data;
                            bits_reg <= 3'd4;
                        end else if (!ten_reg) begin
                            ser_reg <= ptf_pkg::PTF_SER_IDLE;
                        end
                    end else if (bcyc_reg == 4'(`PTF_BT_CYC - 1)) begin
                        bcyc_reg <= 4'h0;
                        sh_reg <= sh_reg >> 1;
                        bits_reg <= bits_reg - 3'd1;
                        if (bits_reg == 3'd1 && rd_valid) begin
                            sh_reg <= rd_nib.data;
                            bits_reg <= 3'd4;
                        end
                    end else begin
                        bcyc_reg <= bcyc_reg + 4'h1;
                    end
                end
                default: begin
                    ser_reg <= ptf_pkg::PTF_SER_IDLE;
                end
            endcase
        end
    end

    assign ser_bit = (bits_reg != 3'd0) &
        ((bcyc_reg < 4'(`PTF_BT_CYC / 2)) ? ~sh_reg[0] : sh_reg[0]);

    // link pulse bursts only while idle; a frame aborts a burst
    assign flp_en = i_autoneg_en & o_phy_ready & ~tx_busy;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flp_reg <= ptf_pkg::PTF_FLP_WAIT;
            flp_int_reg <= 32'h0000_0000;
            flp_t_reg <= 32'h0000_0000;
            flp_idx_reg <= 5'h00;
        end else if (!flp_en) begin
            flp_reg <= ptf_pkg::PTF_FLP_WAIT;
            flp_int_reg <= 32'h0000_0000;
        end else begin
            // burst starts are a fixed interval apart
            flp_int_reg <= (flp_int_reg >= FLP_INT_CYC - 1) ?
                32'h0000_0000 : flp_int_reg + 32'h0000_0001;
            unique case (flp_reg)
                ptf_pkg::PTF_FLP_WAIT: begin
                    flp_t_reg <= 32'h0000_0000;
                    flp_idx_reg <= 5'h00;
                    if (flp_int_reg == 32'h0000_0000) begin
                        flp_reg <= ptf_pkg::PTF_FLP_BURST;
                    end
                end
                ptf_pkg::PTF_FLP_BURST: begin
                    if (flp_idx_reg == 5'(`PTF_FLP_WORD_W) &&
                        flp_t_reg == `PTF_FLP_PW_CYC - 1) begin
                        flp_reg <= ptf_pkg::PTF_FLP_WAIT;
                    end else if (flp_t_reg >= FLP_CLK_CYC - 1) begin
                        flp_t_reg <= 32'h0000_0000;
                        flp_idx_reg <= flp_idx_reg + 5'h01;
                    end else begin
                        flp_t_reg <= flp_t_reg + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    assign flp_pulse = (flp_reg == ptf_pkg::PTF_FLP_BURST) &
        ((flp_t_reg < `PTF_FLP_PW_CYC) |
         ((flp_idx_reg < 5'(`PTF_FLP_WORD_W)) &
          i_flp_word[flp_idx_reg[3:0]] &
          (flp_t_reg >= FLP_DATA_CYC) &
          (flp_t_reg < FLP_DATA_CYC + `PTF_FLP_PW_CYC)));

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_twisted_pair_tx_out <= 1'b0;
        end else begin
            o_twisted_pair_tx_out <= ser_bit | flp_pulse;
        end
    end
endmodule

// ### ptf_top_assertions.sv
// checker for the ptf_top timing relations, bound to the top module
// assumes every port is sampled on i_clk; tx enable is watched unsynced
`timescale 1ns/1ps
module ptf_checker #(
    parameter int unsigned JAB_CYC = 200,
    parameter int unsigned UNJAB_CYC = 400,
    parameter int unsigned RST_REC_CYC = 50
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // watched ports
    input wire logic i_tx_en,
    input wire logic i_mode_10m,
    input wire logic o_crs,
    input wire logic o_col,
    input wire logic o_jabber,
    input wire logic o_phy_ready,
    input wire logic o_twisted_pair_tx_out
);
    logic [31:0] hi_cnt, lo_cnt, col_len, rst_cnt;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // pin-side run lengths; sync delay is absorbed by the slack
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_cnt <= '0;
            lo_cnt <= '0;
            col_len <= '0;
            rst_cnt <= '0;
        end else begin
            hi_cnt <= i_tx_en ? hi_cnt + 1 : '0;
            lo_cnt <= i_tx_en ? '0 : lo_cnt + 1;
            col_len <= o_col ? col_len + 1 : '0;
            rst_cnt <= rst_cnt + 1;
        end
    end
    property p_crs_on;
        $rose(i_tx_en) && o_phy_ready && i_mode_10m && !o_jabber
            |-> ##[18:48] o_crs;
    endproperty
    a_crs_on: assert property (p_crs_on)
        else $error("carrier sense late");
    property p_crs_fall;
        $fell(o_crs) && !o_jabber |-> !$past(i_tx_en, 10);
    endproperty
    a_crs_fall: assert property (p_crs_fall)
        else $error("carrier sense fell early");
    property p_crs_off;
        $fell(i_tx_en) && o_crs && !o_jabber |-> ##[8:30] !o_crs;
    endproperty
    a_crs_off: assert property (p_crs_off)
        else $error("carrier sense held too long");
    property p_sqe_dly;
        $rose(o_col) && !o_jabber |-> !$past(i_tx_en, 64);
    endproperty
    a_sqe_dly: assert property (p_sqe_dly)
        else $error("heartbeat too early");
    property p_sqe_wid;
        $fell(o_col) && !$past(o_jabber) && !$past(o_jabber, 2)
            |-> col_len >= 50 && col_len <= 150;
    endproperty
    a_sqe_wid: assert property (p_sqe_wid)
        else $error("heartbeat width wrong");
    property p_jab_on;
        $rose(o_jabber) |-> hi_cnt >= JAB_CYC && hi_cnt <= JAB_CYC + 30;
    endproperty
    a_jab_on: assert property (p_jab_on)
        else $error("jabber entry time wrong");
    property p_unjab;
        $fell(o_jabber) |-> lo_cnt >= UNJAB_CYC && lo_cnt <= UNJAB_CYC + 30;
    endproperty
    a_unjab: assert property (p_unjab)
        else $error("unjabber time wrong");
    property p_jab_col;
        o_jabber && $past(o_jabber) |-> o_col;
    endproperty
    a_jab_col: assert property (p_jab_col)
        else $error("collision low in jabber");
    property p_flp_pw;
        $rose(o_twisted_pair_tx_out) && lo_cnt > 2000
            |-> o_twisted_pair_tx_out[*8] ##1 o_twisted_pair_tx_out
            ##1 o_twisted_pair_tx_out ##1 !o_twisted_pair_tx_out;
    endproperty
    a_flp_pw: assert property (p_flp_pw)
        else $error("link pulse width wrong");
    property p_rdy;
        $rose(o_phy_ready)
            |-> rst_cnt >= RST_REC_CYC - 1 && rst_cnt <= RST_REC_CYC + 1;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("reset recovery time wrong");
    property p_quiet;
        !o_phy_ready |-> !o_crs && !o_col && !o_twisted_pair_tx_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("activity before recovery");
    c_frame: cover property ($rose(o_crs));
    c_jab: cover property ($rose(o_jabber));
    c_flp: cover property ($rose(o_twisted_pair_tx_out) && lo_cnt > 2000);
endmodule
bind ptf_top ptf_checker #(.JAB_CYC(JAB_CYC), .UNJAB_CYC(UNJAB_CYC),
    .RST_REC_CYC(RST_REC_CYC)) i_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_tx_en(i_tx_en), .i_mode_10m(i_mode_10m), .o_crs(o_crs),
    .o_col(o_col), .o_jabber(o_jabber), .o_phy_ready(o_phy_ready),
    .o_twisted_pair_tx_out(o_twisted_pair_tx_out));

// ### ptf_mac_model.sv
// controller model: link clock and transmit pins of the mac
// assumes the block samples enable and nibble on the rising link clock
`timescale 1ns/1ps
module ptf_mac_model (
    // link side
    output logic o_tx_clk,
    output logic o_tx_en,
    output logic [3:0] o_txd,
    // flow control
    input wire logic i_tx_ready
);
    int lost;
    // free running: the link domain needs edges to leave reset
    initial begin
        o_tx_clk = 1'b0;
        o_tx_en = 1'b0;
        o_txd = 4'h0;
        lost = 0;
        #13;
        forever #40 o_tx_clk = ~o_tx_clk;
    end
    // mii cannot stall: refused nibbles are counted, not resent
    task automatic frame(input int n, input logic [3:0] first);
        lost = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge o_tx_clk);
            o_tx_en = 1'b1;
            o_txd = first + 4'(i);
            if (i_tx_ready !== 1'b1) lost++;
        end
        @(negedge o_tx_clk);
        o_tx_en = 1'b0;
        // released bus shows the inverse so stale data cannot pass
        o_txd = ~o_txd;
    endtask
endmodule

// ### tb_ptf_top.sv
// self-checking bench for ptf_top with the controller model on the link
// assumes ptf_params.svh on the include path; timers shortened
`timescale 1ns/1ps
`include "ptf_params.svh"
module tb_ptf_top;
    localparam int unsigned JAB = 200;
    localparam int unsigned UNJAB = 400;
    localparam int unsigned FDATA = 20;
    localparam int unsigned FCLK = 50;
    localparam int unsigned FINT = 2000;
    localparam int unsigned RREC = 50;
    logic i_clk, i_reset_n, i_tx_clk, i_tx_en, i_mode_10m, i_autoneg_en;
    logic [`PTF_NIB_W-1:0] i_txd;
    logic [`PTF_FLP_WORD_W-1:0] i_flp_word;
    logic o_tx_ready, o_crs, o_col, o_jabber, o_phy_ready;
    logic o_twisted_pair_tx_out;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    ptf_top #(.JAB_CYC(JAB), .UNJAB_CYC(UNJAB), .FLP_DATA_CYC(FDATA),
        .FLP_CLK_CYC(FCLK), .FLP_INT_CYC(FINT), .RST_REC_CYC(RREC)) i_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_tx_clk(i_tx_clk),
        .i_tx_en(i_tx_en), .i_txd(i_txd), .o_tx_ready(o_tx_ready),
        .i_mode_10m(i_mode_10m), .i_autoneg_en(i_autoneg_en),
        .i_flp_word(i_flp_word), .o_crs(o_crs), .o_col(o_col),
        .o_jabber(o_jabber), .o_phy_ready(o_phy_ready),
        .o_twisted_pair_tx_out(o_twisted_pair_tx_out));
    ptf_mac_model i_mac (.o_tx_clk(i_tx_clk), .o_tx_en(i_tx_en),
        .o_txd(i_txd), .i_tx_ready(o_tx_ready));
    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic in_rng(input logic [31:0] v, lo, hi);
        return v >= lo && v <= hi;
    endfunction
    function automatic logic [31:0] since(input time ts);
        return 32'(($time - ts) / 10);
    endfunction
    function automatic logic sig(input int s);
        case (s)
            0: return o_crs;
            1: return o_col;
            2: return o_twisted_pair_tx_out;
            3: return o_jabber;
            4: return o_phy_ready;
            default: return i_tx_en;
        endcase
    endfunction
    // polls on the falling edge so registered outputs have settled
    task automatic wait_for(input int s, input logic lvl, input int lim);
        int k;
        k = 0;
        while (sig(s) !== lvl && k < lim) begin
            @(negedge i_clk);
            k++;
        end
        chk(sig(s), lvl);
    endtask
    task automatic t_reset;
        @(negedge i_clk);
        i_reset_n = 1'b0;
        @(negedge i_clk);
        chk({o_crs, o_col, o_jabber, o_phy_ready, o_twisted_pair_tx_out}, 0);
        i_reset_n = 1'b1;
        wait_for(4, 1'b1, 500);
        chk(in_rng(cyc_since_rel(), RREC - 1, RREC + 2), 1'b1);
    endtask
    time rel_t;
    always @(posedge i_reset_n) rel_t = $time;
    function automatic logic [31:0] cyc_since_rel();
        return since(rel_t);
    endfunction
    task automatic t_flp;
        time ts;
        logic [31:0] rise_q[$];
        logic [31:0] exp_q[$];
        int w;
        i_flp_word = 16'hA5C3;
        i_autoneg_en = 1'b1;
        wait_for(2, 1'b1, FINT + 100);
        ts = $time;
        w = 0;
        repeat (17 * FCLK + 10) begin
            if (o_twisted_pair_tx_out === 1'b1) begin
                if (w == 0) rise_q.push_back(since(ts));
                w++;
            end else if (w != 0) begin
                chk(w, `PTF_FLP_PW_CYC);
                w = 0;
            end
            @(negedge i_clk);
        end
        for (int k = 0; k < 17; k++) begin
            exp_q.push_back(k * FCLK);
            if (k < 16 && i_flp_word[k]) exp_q.push_back(k * FCLK + FDATA);
        end
        chk(rise_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(rise_q[i], exp_q[i]);
        wait_for(2, 1'b1, FINT);
        chk(in_rng(since(ts), FINT - 1, FINT + 1), 1'b1);
        repeat (900) @(negedge i_clk);
        i_autoneg_en = 1'b0;
    endtask
    task automatic t_frame;
        time ts;
        time tf;
        logic [15:0] bits;
        fork
            i_mac.frame(4, 4'h2);
            begin
                wait_for(5, 1'b1, 400);
                @(posedge i_tx_clk);
                ts = $time;
                wait_for(0, 1'b1, 100);
                chk(in_rng(since(ts), 20, 40), 1'b1);
                wait_for(5, 1'b0, 100);
                tf = $time;
                wait_for(0, 1'b0, 100);
                chk(in_rng(since(tf), 10, 26), 1'b1);
                wait_for(1, 1'b1, 300);
                chk(in_rng(since(tf), 65, 160), 1'b1);
                tf = $time;
                wait_for(1, 1'b0, 300);
                chk(in_rng(since(tf), 50, 150), 1'b1);
                wait_for(2, 1'b1, 900);
                chk(in_rng(since(ts), 725, 760), 1'b1);
                repeat (7) @(negedge i_clk);
                for (int j = 0; j < 16; j++) begin
                    bits[j] = o_twisted_pair_tx_out;
                    repeat (`PTF_BT_CYC) @(negedge i_clk);
                end
                chk(bits, 16'h5432);
            end
        join
        repeat (200) @(negedge i_clk);
    endtask
    // more nibbles than the fifo holds before the line starts draining
    task automatic t_fill;
        i_mac.frame(22, 4'h1);
        chk(i_mac.lost > 0, 1'b1);
        repeat (2500) @(negedge i_clk);
        chk(o_tx_ready, 1'b1);
    endtask
    task automatic t_mode;
        i_mode_10m = 1'b0;
        i_mac.frame(4, 4'h7);
        chk(o_crs, 1'b0);
        repeat (100) @(negedge i_clk);
        chk(o_col, 1'b0);
        i_mode_10m = 1'b1;
    endtask
    task automatic t_jabber;
        time ts;
        fork
            i_mac.frame(40, 4'h0);
            begin
                wait_for(5, 1'b1, 400);
                ts = $time;
                wait_for(3, 1'b1, 400);
                chk(in_rng(since(ts), JAB, JAB + 30), 1'b1);
                @(negedge i_clk);
                chk(o_col, 1'b1);
                wait_for(5, 1'b0, 400);
                ts = $time;
                wait_for(3, 1'b0, UNJAB + 100);
                chk(in_rng(since(ts), UNJAB, UNJAB + 30), 1'b1);
            end
        join
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_mode_10m = 1'b1;
        i_autoneg_en = 1'b0;
        i_flp_word = 16'h0000;
        repeat (12) @(negedge i_clk);
        t_reset;
        t_flp;
        t_frame;
        t_fill;
        t_mode;
        t_jabber;
        t_reset;
        t_frame;
        end_of_test;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test;
        end
    end
endmodule
